// *** logic/cache_pkg.sv ***
// Function
// - sequential read after random read: both pointers to slot after last read, then fetch
// - after a read is delivered, keep reading ahead until a set amount is held
// - read starting right after previous read is served from buffered sectors
// - sequential partial hit starts read-ahead together with host delivery
// - after hit delivery, read-ahead goes on into the freed area
// - full hit: host pointer at stored copy, cache kept, no new read-ahead
// - full hit during read-ahead: deliver at once, read-ahead continues
// - partial hit: host pointer at cached part, disk pointer just after it
// - partial hit: deliver cached part while reading the rest from medium
// - write caching on: complete once all host sectors are received
// - sequential write while previous media write runs: continue, no search
// - sequential write after media write finished: normal search first
// - random write: complete after transfer, media write after previous one ends
// - resets and write-cache disable wait until pending data is written
// - written sectors serve later reads of the same address
// - media write error: retry, then abandon sector and continue with next
// - after unrecovered write error: refuse next non-write command, report saved status
// - write after error: write its data first, then report saved error
// - unrecovered write error turns write caching off until feature command
// - write caching defaults to enabled at power-up
// - write-back only for single, multiple and DMA write commands
// - no error report when alternate sector assignment succeeds
// - read caching disabled: no read served from cache
// - cache invalidated on reset, power-off and commands ending in error
package cache_pkg;

  localparam int LBA_W      = 16;
  localparam int CNT_W      = 8;
  localparam int PTR_W      = 6;
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int OP_W       = 3;

  // =====================================================================
  // segment, sector, retry and error figures
  localparam logic [PTR_W:0]   CACHE_MAX       = 7'h3F;
  localparam logic [PTR_W-1:0] RA_LIMIT        = 6'h30;
  localparam logic [7:0]       WORD_LAST       = 8'hFF;
  localparam logic [1:0]       RETRY_MAX       = 2'h3;
  localparam logic [7:0]       ERR_CODE_WFAULT = 8'h10;

  // =====================================================================
  // command codes
  localparam logic [OP_W-1:0] OP_READ_SECT  = 3'h0;
  localparam logic [OP_W-1:0] OP_READ_MULT  = 3'h1;
  localparam logic [OP_W-1:0] OP_READ_DMA   = 3'h2;
  localparam logic [OP_W-1:0] OP_WRITE_SECT = 3'h3;
  localparam logic [OP_W-1:0] OP_WRITE_MULT = 3'h4;
  localparam logic [OP_W-1:0] OP_WRITE_DMA  = 3'h5;
  localparam logic [OP_W-1:0] OP_SET_FEAT   = 3'h6;
  localparam logic [OP_W-1:0] OP_OTHER      = 3'h7;

  localparam logic [1:0] FEAT_WC_ON  = 2'h0;
  localparam logic [1:0] FEAT_WC_OFF = 2'h1;
  localparam logic [1:0] FEAT_RC_ON  = 2'h2;
  localparam logic [1:0] FEAT_RC_OFF = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HRD  = 4'h2,
    ST_HWR  = 4'h4,
    ST_WAIT = 4'h8
  } state_t;

endpackage

// *** logic/disk_cache.sv ***
`timescale 1ns/1ps
// =====================================================================
// write data fifo
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_t;
  fifo_t f_ff, nxt_f;
  logic  push, pop;

  assign in_ready  = (f_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_ff.cnt != '0);
  assign out_data  = f_ff.mem[f_ff.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;

  always_comb begin
    nxt_f = f_ff;
    if (push) begin
      nxt_f.mem[f_ff.wr] = in_data;
      nxt_f.wr           = f_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_f.rd = f_ff.rd + 1'b1;
    end
    if (push && !pop) begin
      nxt_f.cnt = f_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_f.cnt = f_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f_ff <= '0;
    end else begin
      f_ff <= nxt_f;
    end
  end
endmodule // sync_fifo

// =====================================================================
// buffer cache manager
module disk_cache
  import cache_pkg::*;
(
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RESET_N,
  input  wire logic              I_CMD_VALID,
  input  wire logic [OP_W-1:0]   I_CMD_OP,
  input  wire logic [LBA_W-1:0]  I_CMD_LBA,
  input  wire logic [CNT_W-1:0]  I_CMD_CNT,
  output logic                   O_CMD_READY,
  input  wire logic              I_HOST_SECT_DONE,
  output logic                   O_HOST_SECT_AVAIL,
  output logic [PTR_W-1:0]       O_HOST_PTR,
  output logic                   O_RD_FROM_WBUF,
  input  wire logic              I_HOST_WVALID,
  input  wire logic [DATA_W-1:0] I_HOST_WDATA,
  output logic                   O_HOST_WREADY,
  output logic [PTR_W-1:0]       O_DISK_PTR,
  output logic [LBA_W-1:0]       O_DISK_LBA,
  output logic                   O_DISK_RD_REQ,
  input  wire logic              I_DISK_RSECT_DONE,
  output logic [LBA_W-1:0]       O_DISK_WR_LBA,
  output logic                   O_DISK_WR_REQ,
  output logic                   O_DISK_SEEK,
  output logic                   O_DISK_WVALID,
  output logic [DATA_W-1:0]      O_DISK_WDATA,
  input  wire logic              I_DISK_WREADY,
  input  wire logic              I_DISK_WSECT_DONE,
  input  wire logic              I_DISK_WFAULT,
  input  wire logic              I_DISK_REASSIGN_OK,
  output logic                   O_DISK_RETRY,
  input  wire logic              I_SOFT_RST_REQ,
  input  wire logic              I_HARD_RST_REQ,
  input  wire logic              I_POWER_OFF,
  output logic                   O_RESET_GO,
  output logic                   O_INT_DONE,
  output logic                   O_INT_ERR,
  output logic [7:0]             O_ERR_STATUS,
  output logic [LBA_W-1:0]       O_ERR_LBA,
  output logic                   O_WC_EN,
  output logic                   O_RC_EN
);

  typedef struct packed {
    state_t             st;
    logic               cmd_rdy;
    logic               host_avail;
    logic [PTR_W-1:0]   host_ptr;
    logic [PTR_W-1:0]   disk_ptr;
    logic [PTR_W-1:0]   cache_ptr;
    logic [LBA_W-1:0]   cache_lba;
    logic [PTR_W:0]     cache_cnt;
    logic               cache_vld;
    logic [LBA_W-1:0]   disk_lba;
    logic [CNT_W-1:0]   rd_left;
    logic               need;
    logic               ra_on;
    logic               full_hit;
    logic               rd_wbuf;
    logic [LBA_W-1:0]   last_rd_end;
    logic               wc_en;
    logic               rc_en;
    logic               wb_vld;
    logic [LBA_W-1:0]   wb_lba;
    logic [CNT_W-1:0]   wb_cnt;
    logic [LBA_W-1:0]   wr_end;
    logic [LBA_W-1:0]   wr_lba;
    logic [CNT_W:0]     wr_left;
    logic               q_vld;
    logic [LBA_W-1:0]   q_lba;
    logic [CNT_W:0]     q_cnt;
    logic [CNT_W-1:0]   rx_left;
    logic [7:0]         rx_word;
    logic               cached;
    logic [1:0]         retry;
    logic               err_pend;
    logic               rep_err;
    logic [LBA_W-1:0]   err_lba;
    logic [7:0]         err_stat;
    logic               rst_pend;
    logic               wcoff_pend;
    logic               rd_req;
    logic               wr_req;
    logic               seek;
    logic               retry_p;
    logic               rst_go;
    logic               int_done;
    logic               int_err;
  } cache_t;

  cache_t           s, n;
  logic             acc, is_rd, is_wr, hit, full, seq_rd, wb_hit, inval, push;
  logic             fifo_in_rdy, abandon;
  logic [LBA_W-1:0] off, wb_off;
  logic [LBA_W:0]   end_rel, wb_end_rel;
  logic [PTR_W-1:0] held, nheld;

  assign acc   = I_CMD_VALID && s.cmd_rdy;
  assign is_rd = (I_CMD_OP == OP_READ_SECT) || (I_CMD_OP == OP_READ_MULT)
              || (I_CMD_OP == OP_READ_DMA);
  // write-back applies to these three only
  assign is_wr = (I_CMD_OP == OP_WRITE_SECT) || (I_CMD_OP == OP_WRITE_MULT)
              || (I_CMD_OP == OP_WRITE_DMA);
  assign off        = I_CMD_LBA - s.cache_lba;
  assign end_rel    = {1'b0, off} + {{(LBA_W-CNT_W+1){1'b0}}, I_CMD_CNT};
  assign hit        = s.rc_en && s.cache_vld
                   && (off < {{(LBA_W-PTR_W-1){1'b0}}, s.cache_cnt});
  assign full       = hit && (end_rel <= {{(LBA_W-PTR_W){1'b0}}, s.cache_cnt});
  assign seq_rd     = (I_CMD_LBA == s.last_rd_end);
  assign wb_off     = I_CMD_LBA - s.wb_lba;
  assign wb_end_rel = {1'b0, wb_off} + {{(LBA_W-CNT_W+1){1'b0}}, I_CMD_CNT};
  assign wb_hit     = s.rc_en && s.wb_vld
                   && (wb_end_rel <= {{(LBA_W-CNT_W+1){1'b0}}, s.wb_cnt});
  assign held       = s.disk_ptr - s.host_ptr;
  assign push       = I_HOST_WVALID && fifo_in_rdy && (s.st == ST_HWR) && (s.rx_left != '0);
  assign abandon    = (s.wr_left != '0) && !I_DISK_WSECT_DONE && !I_DISK_REASSIGN_OK
                   && I_DISK_WFAULT && (s.retry == RETRY_MAX);

  // =====================================================================
  // next state
  always_comb begin
    n          = s;
    inval      = 1'b0;
    n.int_done = 1'b0;
    n.int_err  = 1'b0;
    n.seek     = 1'b0;
    n.retry_p  = 1'b0;
    n.rst_go   = 1'b0;

    // background media write
    if (s.wr_left != '0) begin
      if (I_DISK_WSECT_DONE || I_DISK_REASSIGN_OK) begin
        n.wr_left = s.wr_left - 1'b1;
        n.wr_lba  = s.wr_lba + 1'b1;
        n.retry   = '0;
      end else if (I_DISK_WFAULT) begin
        if (s.retry != RETRY_MAX) begin
          n.retry   = s.retry + 1'b1;
          n.retry_p = 1'b1;
        end else begin
          n.wr_left  = s.wr_left - 1'b1;
          n.wr_lba   = s.wr_lba + 1'b1;
          n.retry    = '0;
          n.err_pend = 1'b1;
          n.err_lba  = s.wr_lba;
          n.err_stat = ERR_CODE_WFAULT;
          n.wc_en    = 1'b0;
        end
      end
    end else if (s.q_vld) begin
      // queued random write starts only now, with a search
      n.wr_left = s.q_cnt;
      n.wr_lba  = s.q_lba;
      n.q_vld   = 1'b0;
      n.seek    = 1'b1;
    end

    // medium fills the read segment
    if (I_DISK_RSECT_DONE && s.rd_req) begin
      n.disk_ptr = s.disk_ptr + 1'b1;
      n.disk_lba = s.disk_lba + 1'b1;
      if (s.cache_cnt == CACHE_MAX) begin
        n.cache_ptr = s.cache_ptr + 1'b1;
        n.cache_lba = s.cache_lba + 1'b1;
      end else begin
        n.cache_cnt = s.cache_cnt + 1'b1;
      end
    end

    // host write words into the fifo, counted per sector
    if (push) begin
      n.rx_word = s.rx_word + 1'b1;
      if (s.rx_word == WORD_LAST) begin
        n.rx_left = s.rx_left - 1'b1;
      end
    end

    case (s.st)
      ST_IDLE: begin
        if (s.rst_pend && (s.wr_left == '0) && !s.q_vld) begin
          n.rst_go   = 1'b1;
          n.rst_pend = 1'b0;
          n.err_pend = 1'b0;
          inval      = 1'b1;
        end
        if (s.wcoff_pend && (s.wr_left == '0) && !s.q_vld) begin
          n.wc_en      = 1'b0;
          n.wcoff_pend = 1'b0;
          n.int_done   = 1'b1;
        end
        if (acc) begin
          if (s.err_pend && !is_wr) begin
            n.int_err  = 1'b1;
            n.err_pend = 1'b0;
            inval      = 1'b1;
          end else if (is_rd) begin
            n.rd_left     = I_CMD_CNT;
            n.last_rd_end = I_CMD_LBA + LBA_W'(I_CMD_CNT);
            n.full_hit    = 1'b0;
            n.rd_wbuf     = 1'b0;
            n.st          = ST_HRD;
            if (wb_hit) begin
              n.rd_wbuf = 1'b1;
              n.need    = 1'b0;
            end else if (full) begin
              n.host_ptr = s.cache_ptr + off[PTR_W-1:0];
              n.full_hit = 1'b1;
              n.need     = 1'b0;
            end else if (hit) begin
              n.host_ptr = s.cache_ptr + off[PTR_W-1:0];
              n.disk_ptr = s.cache_ptr + s.cache_cnt[PTR_W-1:0];
              n.disk_lba = s.cache_lba + LBA_W'(s.cache_cnt);
              n.need     = 1'b1;
              if (seq_rd) begin
                n.ra_on = 1'b1;
              end
            end else begin
              n.host_ptr  = s.disk_ptr;
              n.disk_ptr  = s.disk_ptr;
              n.cache_ptr = s.disk_ptr;
              n.cache_lba = I_CMD_LBA;
              n.cache_cnt = '0;
              n.cache_vld = 1'b1;
              n.disk_lba  = I_CMD_LBA;
              n.need      = 1'b1;
              n.ra_on     = 1'b0;
            end
          end else if (is_wr) begin
            n.cached    = s.wc_en && !s.err_pend;
            n.rep_err   = s.err_pend;
            n.err_pend  = 1'b0;
            n.rx_left   = I_CMD_CNT;
            n.rx_word   = '0;
            n.wr_end    = I_CMD_LBA + LBA_W'(I_CMD_CNT);
            n.wb_vld    = 1'b1;
            n.wb_lba    = I_CMD_LBA;
            n.wb_cnt    = I_CMD_CNT;
            n.cache_vld = 1'b0;
            n.ra_on     = 1'b0;
            n.st        = ST_HWR;
            if (s.wr_left != '0) begin
              if (I_CMD_LBA == s.wr_end) begin
                n.wr_left = n.wr_left + (CNT_W+1)'(I_CMD_CNT);
              end else begin
                n.q_vld = 1'b1;
                n.q_lba = I_CMD_LBA;
                n.q_cnt = (CNT_W+1)'(I_CMD_CNT);
              end
            end else begin
              n.wr_left = (CNT_W+1)'(I_CMD_CNT);
              n.wr_lba  = I_CMD_LBA;
              n.seek    = 1'b1;
            end
          end else if (I_CMD_OP == OP_SET_FEAT) begin
            n.int_done = 1'b1;
            if (I_CMD_LBA[1:0] == FEAT_WC_ON) begin
              n.wc_en = 1'b1;
            end else if (I_CMD_LBA[1:0] == FEAT_WC_OFF) begin
              if ((s.wr_left != '0) || s.q_vld) begin
                n.wcoff_pend = 1'b1;
                n.int_done   = 1'b0;
              end else begin
                n.wc_en = 1'b0;
              end
            end else if (I_CMD_LBA[1:0] == FEAT_RC_ON) begin
              n.rc_en = 1'b1;
            end else begin
              n.rc_en = 1'b0;
              inval   = 1'b1;
            end
          end else begin
            n.int_done = 1'b1;
            inval      = 1'b1;
          end
        end
      end
      ST_HRD: begin
        if (I_HOST_SECT_DONE && s.host_avail) begin
          n.rd_left = s.rd_left - 1'b1;
          if (!s.rd_wbuf) begin
            n.host_ptr = s.host_ptr + 1'b1;
          end
        end
        if (s.rd_left == '0) begin
          n.int_done = 1'b1;
          n.need     = 1'b0;
          n.rd_wbuf  = 1'b0;
          if (!s.full_hit && !s.rd_wbuf) begin
            n.ra_on = 1'b1;
          end
          n.st = ST_IDLE;
        end
      end
      ST_HWR: begin
        if (s.rx_left == '0) begin
          if (s.cached) begin
            n.int_done = 1'b1;
            n.st       = ST_IDLE;
          end else begin
            n.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if ((s.wr_left == '0) && !s.q_vld) begin
          if (s.rep_err || s.err_pend) begin
            n.int_err  = 1'b1;
            n.rep_err  = 1'b0;
            n.err_pend = 1'b0;
            inval      = 1'b1;
          end else begin
            n.int_done = 1'b1;
          end
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // a fresh abandon outranks any clear in the same cycle
    if (abandon) begin
      n.err_pend = 1'b1;
      n.wc_en    = 1'b0;
    end
    if (I_SOFT_RST_REQ || I_HARD_RST_REQ) begin
      n.rst_pend = 1'b1;
    end
    if (I_POWER_OFF || inval) begin
      n.cache_vld = 1'b0;
      n.wb_vld    = 1'b0;
      n.ra_on     = 1'b0;
    end

    nheld        = n.disk_ptr - n.host_ptr;
    n.rd_req     = (n.need || n.ra_on) && (nheld < RA_LIMIT) && (n.wr_left == '0);
    n.wr_req     = (n.wr_left != '0);
    n.host_avail = (n.st == ST_HRD) && (n.rd_left != '0) && (n.rd_wbuf || (nheld != '0));
    n.cmd_rdy    = (n.st == ST_IDLE) && !n.rst_pend && !n.wcoff_pend && !n.q_vld;
  end

  // =====================================================================
  // state register
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      s           <= '0;
      s.st        <= ST_IDLE;
      s.wc_en     <= 1'b1;
      s.rc_en     <= 1'b1;
    end else begin
      s <= n;
    end
  end

  sync_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (I_CLK_SYS),
    .rst_n     (I_RESET_N),
    .in_valid  (push),
    .in_data   (I_HOST_WDATA),
    .in_ready  (fifo_in_rdy),
    .out_valid (O_DISK_WVALID),
    .out_data  (O_DISK_WDATA),
    .out_ready (I_DISK_WREADY)
  );

  assign O_HOST_WREADY     = fifo_in_rdy && (s.st == ST_HWR) && (s.rx_left != '0);
  assign O_CMD_READY       = s.cmd_rdy;
  assign O_HOST_SECT_AVAIL = s.host_avail;
  assign O_HOST_PTR        = s.host_ptr;
  assign O_RD_FROM_WBUF    = s.rd_wbuf;
  assign O_DISK_PTR        = s.disk_ptr;
  assign O_DISK_LBA        = s.disk_lba;
  assign O_DISK_RD_REQ     = s.rd_req;
  assign O_DISK_WR_LBA     = s.wr_lba;
  assign O_DISK_WR_REQ     = s.wr_req;
  assign O_DISK_SEEK       = s.seek;
  assign O_DISK_RETRY      = s.retry_p;
  assign O_RESET_GO        = s.rst_go;
  assign O_INT_DONE        = s.int_done;
  assign O_INT_ERR         = s.int_err;
  assign O_ERR_STATUS      = s.err_stat;
  assign O_ERR_LBA         = s.err_lba;
  assign O_WC_EN           = s.wc_en;
  assign O_RC_EN           = s.rc_en;

  // =====================================================================
  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  sequence s_wr_accept;
    acc && is_wr;
  endsequence

  property p_seek_new;
    s_wr_accept and (s.wr_left == '0) and !s.q_vld |=> O_DISK_SEEK && O_DISK_WR_REQ;
  endproperty
  a_seek_new: assert property (p_seek_new) else $error("no search on new write");

  property p_seq_no_seek;
    s_wr_accept and (s.wr_left != '0) and (I_CMD_LBA == s.wr_end) |=> !O_DISK_SEEK ##1 !O_DISK_SEEK;
  endproperty
  a_seq_no_seek: assert property (p_seq_no_seek) else $error("search on sequential write");

  property p_cached_done;
    (s.st == ST_HWR) && (s.rx_left == '0) && s.cached && !s.q_vld |=> O_INT_DONE ##1 O_CMD_READY;
  endproperty
  a_cached_done: assert property (p_cached_done) else $error("cached write not completed");

  property p_abandon_wc_off;
    abandon |=> !O_WC_EN && (O_ERR_LBA == $past(s.wr_lba)) && (O_ERR_STATUS == ERR_CODE_WFAULT);
  endproperty
  a_abandon_wc_off: assert property (p_abandon_wc_off) else $error("write cache left on");

  property p_err_refuse;
    acc && s.err_pend && !is_wr |=> O_INT_ERR && !O_INT_DONE ##1 !O_INT_ERR;
  endproperty
  a_err_refuse: assert property (p_err_refuse) else $error("error not reported");

  property p_rst_defer;
    O_RESET_GO |-> ($past(s.wr_left) == '0) && !$past(s.q_vld);
  endproperty
  a_rst_defer: assert property (p_rst_defer) else $error("reset ran with pending data");

  property p_no_overrun;
    O_DISK_RD_REQ |-> (held < RA_LIMIT);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("read-ahead overran host data");

  property p_rc_off;
    acc && is_rd && !s.rc_en |=> (O_HOST_PTR == O_DISK_PTR) && !O_RD_FROM_WBUF;
  endproperty
  a_rc_off: assert property (p_rc_off) else $error("cache used while disabled");

  property p_full_hit;
    acc && is_rd && full && !wb_hit && !s.err_pend
      |=> (s.ra_on == $past(s.ra_on)) && (O_HOST_PTR == $past(s.cache_ptr + off[PTR_W-1:0]));
  endproperty
  a_full_hit: assert property (p_full_hit) else $error("full hit handled wrong");

  property p_retry;
    (s.wr_left != '0) && I_DISK_WFAULT && !I_DISK_WSECT_DONE && !I_DISK_REASSIGN_OK
      && (s.retry != RETRY_MAX) |=> O_DISK_RETRY && O_WC_EN == $past(s.wc_en);
  endproperty
  a_retry: assert property (p_retry) else $error("no retry on write fault");

endmodule // disk_cache

// *** tb/disk_media_model.sv ***
`timescale 1ns/1ps
// =====================================================================
// slow medium: one sector read every 5 cycles, one word taken every 5
module disk_media_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rd_req,
  input  wire logic       wr_req,
  input  wire logic       wvalid,
  input  wire logic [3:0] faults,
  output logic            rsect_done,
  output logic            wready,
  output logic            wsect_done,
  output logic            wfault
);
  int rc;
  int wc;
  int fl;
  always @(posedge clk) begin
    rsect_done <= rst_n && rd_req && rc == 0;
    rc <= (rc + 1) % 5;
    wready <= rst_n && wr_req && rc == 1 && wc < 256;
    wsect_done <= 1'b0;
    wfault <= 1'b0;
    if (wc == 0) fl <= faults;
    if (wvalid && wready) wc <= wc + 1;
    if (wc >= 256) wc <= wc + 1;
    // each failed attempt ends in a fault, a clean one in done only while faults is zero
    if (wc == 259 && fl > 0) begin
      wfault <= 1'b1;
      fl <= fl - 1;
      wc <= 256;
    end
    if (wc == 259 && fl == 0) begin
      wsect_done <= faults == 0;
      wc <= 0;
    end
    if (!rst_n) wc <= 0;
  end
endmodule // disk_media_model

// *** tb/disk_cache_bench.sv ***
`timescale 1ns/1ps
module disk_cache_bench;
  import cache_pkg::*;
  logic clk = 0, rst_n = 0, cv = 0, hsd = 0, hwv = 0, srst = 0, wb_seen = 0;
  logic [OP_W-1:0] op = '0;
  logic [LBA_W-1:0] lba = '0;
  logic [CNT_W-1:0] cnt = '0;
  logic [DATA_W-1:0] hwd = '0, dwd;
  logic [3:0] faults = '0;
  logic [7:0] est;
  logic [LBA_W-1:0] elba;
  logic rdy, avail, rfw, hwr, rrq, wrq, dwv, dwr, rsd, wsd, wf, rgo, idn, ier, wce, rce;
  int miscompares = 0, cmp_count = 0, n_done = 0, n_err = 0, n_go = 0, base, ewc, erc;
  int q[$];
  disk_cache dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CMD_VALID(cv), .I_CMD_OP(op),
    .I_CMD_LBA(lba), .I_CMD_CNT(cnt), .O_CMD_READY(rdy), .I_HOST_SECT_DONE(hsd),
    .O_HOST_SECT_AVAIL(avail), .O_HOST_PTR(), .O_RD_FROM_WBUF(rfw), .I_HOST_WVALID(hwv),
    .I_HOST_WDATA(hwd), .O_HOST_WREADY(hwr), .O_DISK_PTR(), .O_DISK_LBA(),
    .O_DISK_RD_REQ(rrq), .I_DISK_RSECT_DONE(rsd), .O_DISK_WR_LBA(), .O_DISK_WR_REQ(wrq),
    .O_DISK_SEEK(), .O_DISK_WVALID(dwv), .O_DISK_WDATA(dwd), .I_DISK_WREADY(dwr),
    .I_DISK_WSECT_DONE(wsd), .I_DISK_WFAULT(wf), .I_DISK_REASSIGN_OK(1'b0),
    .O_DISK_RETRY(), .I_SOFT_RST_REQ(srst), .I_HARD_RST_REQ(1'b0), .I_POWER_OFF(1'b0),
    .O_RESET_GO(rgo), .O_INT_DONE(idn), .O_INT_ERR(ier), .O_ERR_STATUS(est),
    .O_ERR_LBA(elba), .O_WC_EN(wce), .O_RC_EN(rce));
  disk_media_model media (.clk(clk), .rst_n(rst_n), .rd_req(rrq), .wr_req(wrq),
    .wvalid(dwv), .faults(faults), .rsect_done(rsd), .wready(dwr), .wsect_done(wsd),
    .wfault(wf));
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // =====================================================================
  // monitors: completion pulses and words reaching the medium
  always @(negedge clk) begin
    n_done += (idn === 1'b1);
    n_err += (ier === 1'b1);
    n_go += (rgo === 1'b1);
    wb_seen |= (rfw === 1'b1);
    if (dwv === 1'b1 && dwr === 1'b1) chk(dwd, 16'(q.pop_front()));
  end
  task automatic conclude;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_for(ref int c, input int c0);
    int t = 0;
    while (c == c0 && t++ < 20000) @(posedge clk);
    #1 chk(16'(c), 16'(c0 + 1));
  endtask
  task automatic cmd(input logic [OP_W-1:0] o, input int a, input int n);
    int t = 0;
    cv = 1;
    op = o;
    lba = LBA_W'(a);
    cnt = CNT_W'(n);
    do @(negedge clk); while (rdy !== 1'b1 && ++t < 5000);
    @(posedge clk);
    #1 cv = 0;
  endtask
  task automatic rd(input logic [OP_W-1:0] o, input int a, input int n);
    int c0 = n_done;
    int t = 0;
    cmd(o, a, n);
    repeat (n) begin
      do @(negedge clk); while (avail !== 1'b1 && ++t < 5000);
      @(posedge clk);
      #1 hsd = 1;
      @(posedge clk);
      #1 hsd = 0;
      @(posedge clk);
      #1;
    end
    wait_for(n_done, c0);
  endtask
  task automatic wr(input logic [OP_W-1:0] o, input int a, input bit dr);
    int c0 = n_done;
    int t = 0;
    cmd(o, a, 1);
    repeat (256) begin
      hwv = 1;
      hwd = 16'($urandom);
      q.push_back(hwd);
      do @(negedge clk); while (hwr !== 1'b1 && ++t < 5000);
      @(posedge clk);
      #1;
    end
    hwv = 0;
    wait_for(n_done, c0);
    chk(wrq, 1);
    t = 0;
    // without drain the next write overlaps the running media write
    while (dr && wrq !== 1'b0 && t++ < 20000) @(posedge clk);
    #1;
  endtask
  task automatic feat(input int i);
    int c0 = n_done;
    cmd(OP_SET_FEAT, i, 0);
    wait_for(n_done, c0);
    if (i < 2) ewc = (i == 0);
    else erc = (i == 2);
    chk(16'({wce, rce}), 16'({ewc[0], erc[0]}));
  endtask
  initial begin
    void'($urandom(27647));
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    chk(wce, 1);
    chk(rce, 1);
    base = $urandom % 1000;
    rd(OP_READ_SECT, base, 2);
    chk(rrq, 1);
    for (int i = 1; i < 3; i++) rd(OP_READ_SECT + OP_W'(i), base + 2 * i, 2);
    rd(OP_READ_DMA, base + 1, 2);
    rd(OP_READ_MULT, base + 5, 4);
    $display("reads done");
    for (int i = 0; i < 3; i++)
      wr(OP_WRITE_SECT + OP_W'(i), (i < 2) ? base + 100 + i : base + 300, i == 2);
    rd(OP_READ_SECT, base + 300, 1);
    chk(wb_seen, 1);
    $display("writes done");
    ewc = 1;
    erc = 1;
    for (int k = 0; k < 4; k++) feat(k ^ 1);
    $display("features done");
    faults = 4;
    wr(OP_WRITE_DMA, base + 200, 1);
    faults = 0;
    chk(wce, 0);
    chk(elba, 16'(base + 200));
    n_done = n_done;
    cmd(OP_READ_SECT, base, 1);
    wait_for(n_err, n_err);
    chk(est, ERR_CODE_WFAULT);
    feat(0);
    $display("write fault done");
    srst = 1;
    @(posedge clk);
    #1 srst = 0;
    wait_for(n_go, 0);
    $display("reset done");
    conclude;
  end
  initial begin
    #5000000;
    miscompares++;
    conclude;
  end
endmodule // disk_cache_bench
